/* pmic_gpio_pkg.sv */
// constants, register map and pin function codes for the pin configuration block
// assumes a single 100 MHz clock domain and an 8-bit internal register port
package pmic_gpio_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int PIN_COUNT   = 7;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 8;
  localparam int FUNC_W      = 4;
  localparam int SRC_W       = 3;
  localparam int LED_CODE_W  = 4;
  localparam int LED_MA_W    = 5;
  localparam int ANALOG_PINS = 2;
  localparam int FIRST_ANALOG_PIN = 5;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PULLUP_ENABLE_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] CTRL_ADDR          = 8'h11;
  localparam logic [ADDR_W-1:0] PUSH_PULL_ADDR     = 8'h12;
  localparam logic [ADDR_W-1:0] GPIO_OUT_ADDR      = 8'h13;
  localparam logic [ADDR_W-1:0] PIN_STATUS_ADDR    = 8'h14;
  localparam logic [ADDR_W-1:0] LED_CODE_ADDR      = 8'h15;
  localparam logic [ADDR_W-1:0] COMP_STATUS_ADDR   = 8'h16;
  localparam logic [ADDR_W-1:0] FUNC_BASE_ADDR     = 8'h18;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_RAIL_BIT   = 0;
  localparam int CTRL_POWER_ENABLE_INPUT_BIT  = 1;
  localparam int FUNC_LSB        = 0;
  localparam int SRC_LSB         = 4;
  localparam logic [DATA_W-1:0] PULLUP_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_RESET      = 8'h02;
  localparam logic [DATA_W-1:0] PUSH_PULL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] GPIO_OUT_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] LED_CODE_RESET  = 8'h00;

  // led current: linear 1 mA steps up to this code, 2 mA steps above it
  localparam logic [LED_CODE_W-1:0] LED_LINEAR_MAX = 4'h8;
  // comparator reference in millivolts, fixed in the analog part
  localparam int COMP_REF_MV = 800;

  // ----------------------------------------------------------------
  // pin functions
  // ----------------------------------------------------------------
  typedef enum logic [FUNC_W-1:0] {
    FN_GPIO,
    FN_RESET_OUT,
    FN_INTERRUPT_OUT,
    FN_SUPPLY_ENABLE_OUT,
    FN_GOOD_OUT,
    FN_EXT_GOOD_IN,
    FN_DYN_VOLT_IN,
    FN_VSEL_IN,
    FN_CONV_ON_IN,
    FN_SLEEP_IN,
    FN_DEEP_SLEEP_IN,
    FN_POWER_ENABLE_IN,
    FN_LED_SINK,
    FN_COMP_IN,
    FN_COMP_OUT
  } pin_func_t;

  function automatic logic [DATA_W-1:0] func_reset(input int pin);
    case (pin)
      0:       func_reset = {4'h0, FN_POWER_ENABLE_IN};
      1:       func_reset = {4'h0, FN_RESET_OUT};
      2:       func_reset = {4'h0, FN_INTERRUPT_OUT};
      4:       func_reset = {4'h0, FN_SUPPLY_ENABLE_OUT};
      default: func_reset = {4'h0, FN_GPIO};
    endcase
  endfunction

  function automatic logic [LED_MA_W-1:0] led_ma(input logic [LED_CODE_W-1:0] code);
    if (code <= LED_LINEAR_MAX) begin
      led_ma = {1'b0, code};
    end else begin
      led_ma = 5'({code, 1'b0} - {1'b0, LED_LINEAR_MAX});
    end
  endfunction

endpackage

/* gpio_pin_cell.sv */
// one pin's output driver: function mux, open-drain or push-pull stage
// assumes its inputs come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_cell #(
  parameter int REG_COUNT    = 6,
  parameter bit PUSH_PULL_OK = 1'b1
) (
  input  wire logic                          clock_in,
  input  wire logic                          rst_n_in,
  input  wire pmic_gpio_pkg::pin_func_t      func_in,
  input  wire logic [pmic_gpio_pkg::SRC_W-1:0] source_in,
  input  wire logic                          push_pull_in,
  input  wire logic                          gpio_value_in,
  input  wire logic                          system_reset_active_in,
  input  wire logic                          unmasked_event_pending_in,
  input  wire logic                          external_supply_enable_in,
  input  wire logic [REG_COUNT-1:0]          regulator_power_good_in,
  input  wire logic [1:0]                    comparator_result_in,
  output logic                               pad_out,
  output logic                               pad_oe_out
);
  import pmic_gpio_pkg::*;

  logic level;
  logic active;

  // ----------------------------------------------------------------
  // function mux
  // ----------------------------------------------------------------
  always_comb begin
    level  = 1'b1;
    active = 1'b1;
    case (func_in)
      FN_GPIO:              level = gpio_value_in;
      FN_RESET_OUT:         level = ~system_reset_active_in;
      FN_INTERRUPT_OUT:     level = ~unmasked_event_pending_in;
      FN_SUPPLY_ENABLE_OUT: level = external_supply_enable_in;
      FN_GOOD_OUT: begin
        if (int'(source_in) < REG_COUNT) begin
          level = regulator_power_good_in[source_in];
        end
      end
      FN_COMP_OUT:          level = comparator_result_in[source_in[0]];
      default:              active = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // driver stage
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pad_out    <= 1'b0;
      pad_oe_out <= 1'b0;
    end else if (!active) begin
      pad_out    <= 1'b0;
      pad_oe_out <= 1'b0;
    end else if (push_pull_in && PUSH_PULL_OK) begin
      pad_out    <= level;
      pad_oe_out <= 1'b1;
    end else begin
      pad_out    <= 1'b0;
      pad_oe_out <= ~level;
    end
  end

endmodule
`default_nettype wire

/* pmic_gpio_config.sv */
// pin configuration block: settings registers, per-pin drivers, input routing
// assumes pads resolved outside; register port driven by on-chip logic on clock_in
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - pullup enable bit 0 connects pin 1 pull-up when one
// - pin 1 rail select chooses I/O supply at zero, 5V rail at one
// - pins 2 to 7 pull-ups follow their own enable bits
// - standard pins choose open-drain or push-pull drive
// - pins 6 and 7 drive open-drain only
// - led sink and comparator input functions refused on pins 1 to 5
// - comparator result used internally or routed to another pin
// - led code gives 0-8 mA by 1, then 10-22 mA by 2
// - power-enable operation forces pin 1 to power enable input
// - power enable input low also requests deep sleep
// - pins offer sequencing, supply, scaling, select, good, on/off, sleep functions
// - pins 2, 3, 5 default to reset, interrupt, supply enable
// - pin functions change live without a restart
// - interrupt pin drives low while an unmasked event is pending
module pmic_gpio_config #(
  parameter int REG_COUNT = 6
) (
  input  wire logic                                    clock_in,
  input  wire logic                                    rst_b_in,
  input  wire logic [pmic_gpio_pkg::ADDR_W-1:0]        reg_addr_in,
  input  wire logic [pmic_gpio_pkg::DATA_W-1:0]        reg_wdata_in,
  input  wire logic                                    reg_write_in,
  input  wire logic                                    reg_read_in,
  output logic [pmic_gpio_pkg::DATA_W-1:0]             reg_rdata_out,
  input  wire logic [pmic_gpio_pkg::PIN_COUNT-1:0]     gpio_pad_in,
  output logic [pmic_gpio_pkg::PIN_COUNT-1:0]          gpio_pad_out,
  output logic [pmic_gpio_pkg::PIN_COUNT-1:0]          gpio_pad_oe_out,
  output logic [pmic_gpio_pkg::PIN_COUNT-1:0]          pullup_enable_out,
  output logic                                         pin1_pullup_rail_select_out,
  input  wire logic [pmic_gpio_pkg::ANALOG_PINS-1:0]   comparator_above_ref_in,
  output logic [pmic_gpio_pkg::ANALOG_PINS-1:0]        comparator_enable_out,
  output logic [pmic_gpio_pkg::ANALOG_PINS-1:0]        comparator_result_out,
  output logic [pmic_gpio_pkg::ANALOG_PINS-1:0]        led_sink_enable_out,
  output logic [2*pmic_gpio_pkg::LED_CODE_W-1:0]       led_sink_current_code_out,
  output logic [2*pmic_gpio_pkg::LED_MA_W-1:0]         led_sink_ma_out,
  input  wire logic                                    system_reset_active_in,
  input  wire logic                                    unmasked_event_pending_in,
  input  wire logic                                    external_supply_enable_in,
  input  wire logic [REG_COUNT-1:0]                    regulator_power_good_in,
  output logic                                         external_good_input_out,
  output logic                                         dynamic_voltage_scaling_out,
  output logic [REG_COUNT-1:0]                         voltage_select_out,
  output logic [REG_COUNT-1:0]                         converter_on_request_out,
  output logic                                         sleep_request_out,
  output logic                                         deep_sleep_mode_out,
  output logic                                         power_enable_input_out
);
  import pmic_gpio_pkg::*;

  // the source field can only name this many regulators
  if (REG_COUNT < 1 || REG_COUNT > (1 << SRC_W)) begin : g_bad_count
    $error("REG_COUNT out of range");
  end

  // ----------------------------------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0]             rst_sync_q;
  logic                   rst_n;
  logic [PIN_COUNT-1:0]   pin_meta_q;
  logic [PIN_COUNT-1:0]   pin_sync_q;
  logic [ANALOG_PINS-1:0] comp_meta_q;
  logic [ANALOG_PINS-1:0] comp_sync_q;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q  <= '0;
      pin_sync_q  <= '0;
      comp_meta_q <= '0;
      comp_sync_q <= '0;
    end else begin
      pin_meta_q  <= gpio_pad_in;
      pin_sync_q  <= pin_meta_q;
      comp_meta_q <= comparator_above_ref_in;
      comp_sync_q <= comp_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // settings registers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]     pullup_q;
  logic [DATA_W-1:0]     ctrl_q;
  logic [DATA_W-1:0]     push_pull_q;
  logic [DATA_W-1:0]     gpio_out_q;
  logic [DATA_W-1:0]     led_code_q;
  logic [DATA_W-1:0]     func_q [PIN_COUNT];
  logic [ADDR_W-1:0]     func_idx;
  logic                  func_hit;
  pin_func_t             wr_func;
  pin_func_t             eff_func [PIN_COUNT];

  assign func_idx = reg_addr_in - FUNC_BASE_ADDR;
  assign func_hit = reg_addr_in >= FUNC_BASE_ADDR && func_idx < ADDR_W'(PIN_COUNT);
  assign wr_func  = pin_func_t'(reg_wdata_in[FUNC_LSB +: FUNC_W]);

  // refusal leaves the old function in place; software sees it on read-back
  function automatic logic func_ok(input logic [ADDR_W-1:0] idx, input logic [FUNC_W-1:0] code);
    func_ok = code <= FN_COMP_OUT;
    if ((code == FN_LED_SINK || code == FN_COMP_IN) && idx < ADDR_W'(FIRST_ANALOG_PIN)) begin
      func_ok = 1'b0;
    end
    if (code == FN_POWER_ENABLE_IN && idx != '0) begin
      func_ok = 1'b0;
    end
  endfunction

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pullup_q <= PULLUP_RESET;
    end else if (reg_write_in && reg_addr_in == PULLUP_ENABLE_ADDR) begin
      pullup_q <= {1'b0, reg_wdata_in[PIN_COUNT-1:0]};
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (reg_write_in && reg_addr_in == CTRL_ADDR) begin
      ctrl_q <= {6'h00, reg_wdata_in[CTRL_POWER_ENABLE_INPUT_BIT], reg_wdata_in[CTRL_RAIL_BIT]};
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      push_pull_q <= PUSH_PULL_RESET;
      gpio_out_q  <= GPIO_OUT_RESET;
      led_code_q  <= LED_CODE_RESET;
    end else if (reg_write_in) begin
      if (reg_addr_in == PUSH_PULL_ADDR) begin
        push_pull_q <= {3'h0, reg_wdata_in[4:0]};
      end
      if (reg_addr_in == GPIO_OUT_ADDR) begin
        gpio_out_q <= {1'b0, reg_wdata_in[PIN_COUNT-1:0]};
      end
      if (reg_addr_in == LED_CODE_ADDR) begin
        led_code_q <= reg_wdata_in;
      end
    end
  end

  genvar p;
  generate
    for (p = 0; p < PIN_COUNT; p++) begin : g_pin
      always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
          func_q[p] <= func_reset(p);
        end else if (reg_write_in && func_hit && func_idx == ADDR_W'(p) &&
                     func_ok(func_idx, wr_func)) begin
          func_q[p] <= {1'b0, reg_wdata_in[SRC_LSB +: SRC_W], wr_func};
        end
      end

      if (p == 0) begin : g_first
        assign eff_func[p] = ctrl_q[CTRL_POWER_ENABLE_INPUT_BIT] ? FN_POWER_ENABLE_IN :
                             pin_func_t'(func_q[p][FUNC_LSB +: FUNC_W]);
      end else begin : g_other
        assign eff_func[p] = pin_func_t'(func_q[p][FUNC_LSB +: FUNC_W]);
      end

      gpio_pin_cell #(
        .REG_COUNT    (REG_COUNT),
        .PUSH_PULL_OK (p < FIRST_ANALOG_PIN)
      ) u_cell (
        .clock_in                  (clock_in),
        .rst_n_in                  (rst_n),
        .func_in                   (eff_func[p]),
        .source_in                 (func_q[p][SRC_LSB +: SRC_W]),
        .push_pull_in              (push_pull_q[p]),
        .gpio_value_in             (gpio_out_q[p]),
        .system_reset_active_in    (system_reset_active_in),
        .unmasked_event_pending_in (unmasked_event_pending_in),
        .external_supply_enable_in (external_supply_enable_in),
        .regulator_power_good_in   (regulator_power_good_in),
        .comparator_result_in      (comp_sync_q),
        .pad_out                   (gpio_pad_out[p]),
        .pad_oe_out                (gpio_pad_oe_out[p])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // analog controls
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pullup_enable_out           <= '0;
      pin1_pullup_rail_select_out <= 1'b0;
      led_sink_enable_out         <= '0;
      comparator_enable_out       <= '0;
      comparator_result_out       <= '0;
      led_sink_current_code_out   <= '0;
      led_sink_ma_out             <= '0;
    end else begin
      pullup_enable_out           <= pullup_q[PIN_COUNT-1:0];
      pin1_pullup_rail_select_out <= ctrl_q[CTRL_RAIL_BIT];
      for (int a = 0; a < ANALOG_PINS; a++) begin
        led_sink_enable_out[a]   <= eff_func[FIRST_ANALOG_PIN+a] == FN_LED_SINK;
        comparator_enable_out[a] <= eff_func[FIRST_ANALOG_PIN+a] == FN_COMP_IN;
      end
      comparator_result_out       <= comp_sync_q & comparator_enable_out;
      led_sink_current_code_out   <= led_code_q;
      led_sink_ma_out             <= {led_ma(led_code_q[7:4]), led_ma(led_code_q[3:0])};
    end
  end

  // ----------------------------------------------------------------
  // input function routing
  // ----------------------------------------------------------------
  logic                 good_d;
  logic                 scale_d;
  logic                 sleep_d;
  logic                 deep_d;
  logic                 pwr_d;
  logic [REG_COUNT-1:0] vsel_d;
  logic [REG_COUNT-1:0] conv_d;

  always_comb begin
    good_d  = 1'b0;
    scale_d = 1'b0;
    sleep_d = 1'b0;
    deep_d  = 1'b0;
    pwr_d   = 1'b0;
    vsel_d  = '0;
    conv_d  = '0;
    for (int i = 0; i < PIN_COUNT; i++) begin
      case (eff_func[i])
        FN_EXT_GOOD_IN:     good_d  = good_d | pin_sync_q[i];
        FN_DYN_VOLT_IN:     scale_d = scale_d | pin_sync_q[i];
        FN_SLEEP_IN:        sleep_d = sleep_d | pin_sync_q[i];
        FN_DEEP_SLEEP_IN:   deep_d  = deep_d | pin_sync_q[i];
        FN_POWER_ENABLE_IN: pwr_d   = pwr_d | pin_sync_q[i];
        FN_VSEL_IN: begin
          if (int'(func_q[i][SRC_LSB +: SRC_W]) < REG_COUNT) begin
            vsel_d[func_q[i][SRC_LSB +: SRC_W]] = pin_sync_q[i];
          end
        end
        FN_CONV_ON_IN: begin
          if (int'(func_q[i][SRC_LSB +: SRC_W]) < REG_COUNT) begin
            conv_d[func_q[i][SRC_LSB +: SRC_W]] = pin_sync_q[i];
          end
        end
        default: ;
      endcase
    end
    if (eff_func[0] == FN_POWER_ENABLE_IN && !pin_sync_q[0]) begin
      deep_d = 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      external_good_input_out     <= 1'b0;
      dynamic_voltage_scaling_out <= 1'b0;
      sleep_request_out           <= 1'b0;
      deep_sleep_mode_out         <= 1'b0;
      power_enable_input_out      <= 1'b0;
      voltage_select_out          <= '0;
      converter_on_request_out    <= '0;
    end else begin
      external_good_input_out     <= good_d;
      dynamic_voltage_scaling_out <= scale_d;
      sleep_request_out           <= sleep_d;
      deep_sleep_mode_out         <= deep_d;
      power_enable_input_out      <= pwr_d;
      voltage_select_out          <= vsel_d;
      converter_on_request_out    <= conv_d;
    end
  end

  // ----------------------------------------------------------------
  // read-back, unmapped addresses read zero
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= '0;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        PULLUP_ENABLE_ADDR: reg_rdata_out <= pullup_q;
        CTRL_ADDR:          reg_rdata_out <= ctrl_q;
        PUSH_PULL_ADDR:     reg_rdata_out <= push_pull_q;
        GPIO_OUT_ADDR:      reg_rdata_out <= gpio_out_q;
        PIN_STATUS_ADDR:    reg_rdata_out <= {1'b0, pin_sync_q};
        LED_CODE_ADDR:      reg_rdata_out <= led_code_q;
        COMP_STATUS_ADDR:   reg_rdata_out <= {6'h00, comp_sync_q};
        default:            reg_rdata_out <= func_hit ? func_q[func_idx[2:0]] : '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n);

  sequence pwr_low_s;
    ctrl_q[CTRL_POWER_ENABLE_INPUT_BIT] && !pin_sync_q[0];
  endsequence

  pullup_pin1_a: assert property (
    reg_write_in && reg_addr_in == PULLUP_ENABLE_ADDR |=> ##1 pullup_enable_out[0] == $past(reg_wdata_in[0], 2))
    else $error("pin 1 pull-up does not follow its bit");
  pullup_rest_a: assert property (
    reg_write_in && reg_addr_in == PULLUP_ENABLE_ADDR |=> ##1 pullup_enable_out[6:1] == $past(reg_wdata_in[6:1], 2))
    else $error("pin 2-7 pull-ups do not follow their bits");
  rail_select_a: assert property (
    reg_write_in && reg_addr_in == CTRL_ADDR |=> ##1 pin1_pullup_rail_select_out == $past(reg_wdata_in[CTRL_RAIL_BIT], 2))
    else $error("pull-up rail select wrong");
  open_drain_a: assert property (
    !(gpio_pad_oe_out[5] && gpio_pad_out[5]) && !(gpio_pad_oe_out[6] && gpio_pad_out[6]))
    else $error("analog pin driven high");
  analog_refuse_a: assert property (
    reg_write_in && reg_addr_in == FUNC_BASE_ADDR && wr_func == FN_LED_SINK |=> func_q[0] == $past(func_q[0]))
    else $error("analog function accepted on pin 1");
  push_pull_a: assert property (
    eff_func[3] == FN_GPIO && push_pull_q[3] && gpio_out_q[3] |=> gpio_pad_oe_out[3] && gpio_pad_out[3])
    else $error("push-pull pin not driven high");
  interrupt_pin_a: assert property (
    eff_func[2] == FN_INTERRUPT_OUT && unmasked_event_pending_in |=> gpio_pad_oe_out[2] && !gpio_pad_out[2])
    else $error("interrupt pin not low");
  reset_pin_a: assert property (
    eff_func[1] == FN_RESET_OUT && system_reset_active_in |=> gpio_pad_oe_out[1] && !gpio_pad_out[1])
    else $error("reset pin not low");
  deep_sleep_a: assert property (
    pwr_low_s |=> deep_sleep_mode_out)
    else $error("deep sleep not requested");
  led_map_a: assert property (
    led_code_q[3:0] == 4'h9 |=> led_sink_ma_out[4:0] == 5'h0a)
    else $error("led current code maps wrong");

endmodule
`default_nettype wire

/* pad_world_model.sv */
// board model around the seven pins: resolves each pad level
// assumes the bench sets external drive on clock_in edges
`timescale 1ns/10ps
`default_nettype none
module pad_world_model (
  input  wire logic       clock_in,
  input  wire logic [6:0] pad_in,
  input  wire logic [6:0] oe_in,
  input  wire logic [6:0] pullup_in,
  input  wire logic [6:0] external_supply_enable_output_in,
  input  wire logic [6:0] ext_val_in,
  output logic      [6:0] level_out
);
  logic [6:0] float_q = 7'h55;
  // a floating pin wanders so a stale level never passes for a real one
  always @(posedge clock_in) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (oe_in[i]) level_out[i] = pad_in[i];
      else if (external_supply_enable_output_in[i]) level_out[i] = ext_val_in[i];
      else if (pullup_in[i]) level_out[i] = 1'b1;
      else level_out[i] = float_q[i];
    end
  end
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the pin configuration block
// assumes the pad model above and the design package
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pmic_gpio_pkg::*;
  logic       clock_in, rst_b_in, wr, rd, rst_act, pend, sup_en;
  logic [7:0] addr, wdata, rdata, code;
  logic [6:0] pad, oe, pu, lvl, external_supply_enable_output, ext_val;
  logic [5:0] good, vsel, conv;
  logic [1:0] cmp_in, cmp_en, cmp_res, led_en;
  logic [9:0] ma;
  logic       dslp, power_enable_input, sup_rail, ext_good, scale, sleep;
  int         fail_count, checks_done, cycles;
  pmic_gpio_config dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata), .gpio_pad_in(lvl), .gpio_pad_out(pad),
    .gpio_pad_oe_out(oe), .pullup_enable_out(pu), .pin1_pullup_rail_select_out(sup_rail),
    .comparator_above_ref_in(cmp_in), .comparator_enable_out(cmp_en), .comparator_result_out(cmp_res),
    .led_sink_enable_out(led_en), .led_sink_current_code_out(code), .led_sink_ma_out(ma),
    .system_reset_active_in(rst_act), .unmasked_event_pending_in(pend), .external_supply_enable_in(sup_en),
    .regulator_power_good_in(good), .external_good_input_out(ext_good), .dynamic_voltage_scaling_out(scale),
    .voltage_select_out(vsel), .converter_on_request_out(conv), .sleep_request_out(sleep),
    .deep_sleep_mode_out(dslp), .power_enable_input_out(power_enable_input));
  pad_world_model board (.clock_in(clock_in), .pad_in(pad), .oe_in(oe), .pullup_in(pu),
    .external_supply_enable_output_in(external_supply_enable_output), .ext_val_in(ext_val), .level_out(lvl));
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // bounded run: a hang counts as a mismatch
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
    tick(2);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    addr <= a; rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    tick(1);
    chk(rdata, exp);
  endtask
  task automatic s_reset();
    rdc(8'h10, 8'h00); rdc(8'h11, 8'h02); rdc(8'h18, 8'h0b);
    rdc(8'h19, 8'h01); rdc(8'h1a, 8'h02); rdc(8'h1c, 8'h03);
  endtask
  task automatic s_pullup();
    wrt(8'h10, 8'h7f); chk(pu, 7'h7f);
    wrt(8'h10, 8'h01); chk(pu, 7'h01); rdc(8'h10, 8'h01);
    wrt(8'h11, 8'h03); chk(sup_rail, 1'b1);
    wrt(8'h11, 8'h02); chk(sup_rail, 1'b0); rdc(8'h17, 8'h00);
    wrt(8'h10, 8'h00); chk(pu[0], 1'b0);
  endtask
  task automatic s_refuse();
    wrt(8'h18, 8'h0c); rdc(8'h18, 8'h0b);
    wrt(8'h1b, 8'h0d); rdc(8'h1b, 8'h00);
  endtask
  task automatic s_drive();
    @(posedge clock_in); pend <= 1'b1; tick(2); chk({oe[2], pad[2]}, 2'b10);
    wrt(8'h12, 8'h08); wrt(8'h13, 8'h0c); chk({oe[3], pad[3]}, 2'b11);
    wrt(8'h1a, 8'h00); chk(oe[2], 1'b0);
    wrt(8'h12, 8'h20); rdc(8'h12, 8'h00); chk(oe[3], 1'b0);
    wrt(8'h13, 8'h20); chk(oe[5], 1'b0);
    wrt(8'h13, 8'h00); chk({oe[5], pad[5]}, 2'b10);
    @(posedge clock_in); pend <= 1'b0;
  endtask
  task automatic s_led();
    logic [4:0] e;
    wrt(8'h1d, 8'h0c); wrt(8'h1e, 8'h0c); chk(led_en, 2'b11);
    for (int c = 0; c < 16; c++) begin
      e = (c <= 8) ? 5'(c) : 5'(2 * c - 8);
      wrt(8'h15, {4'(c), 4'(c)}); chk(ma, {e, e});
      chk(code, {4'(c), 4'(c)});
    end
  endtask
  task automatic s_comp();
    wrt(8'h1e, 8'h0d); wrt(8'h1b, 8'h1e); @(posedge clock_in); cmp_in <= 2'b10; tick(5);
    chk({cmp_en[1], cmp_res[1], oe[3]}, 3'b110);
    @(posedge clock_in); cmp_in <= 2'b00; tick(5); chk({cmp_res[1], oe[3], pad[3]}, 3'b010);
  endtask
  task automatic s_power_enable_input();
    // the outside controller pulls the enable low to ask for deep sleep
    @(posedge clock_in); external_supply_enable_output <= 7'h01; ext_val <= 7'h00; tick(5); chk(dslp, 1'b1);
    @(posedge clock_in); ext_val <= 7'h01; tick(5); chk({power_enable_input, dslp}, 2'b10);
  endtask
  task automatic s_route();
    logic [15:0] want [6];
    want = '{16'h8000, 16'h4000, 16'h0900, 16'h0024, 16'h0002, 16'h0001};
    chk({oe[1], oe[4]}, 2'b01);
    @(posedge clock_in); rst_act <= 1'b1; sup_en <= 1'b1; tick(2);
    chk({oe[1], pad[1], oe[4]}, 3'b100);
    wrt(8'h1c, 8'h24); @(posedge clock_in); good <= 6'h3b; tick(2); chk(oe[4], 1'b1);
    @(posedge clock_in); good <= 6'h04; tick(2); chk(oe[4], 1'b0);
    @(posedge clock_in); external_supply_enable_output <= 7'h0d; ext_val <= 7'h0d;
    // pins 3 and 4 take each input function but power enable in turn, pin 4 with source 3
    for (int f = 5; f <= 10; f++) begin
      wrt(8'h1a, 8'(f)); wrt(8'h1b, 8'h30 | 8'(f)); tick(3);
      chk({ext_good, scale, vsel, conv, sleep, dslp}, want[f-5]);
    end
  endtask
  initial begin
    rst_b_in = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00; rst_act = 1'b0; pend = 1'b0;
    sup_en = 1'b0; good = 6'h00; cmp_in = 2'b00; external_supply_enable_output = 7'h00; ext_val = 7'h00;
    fail_count = 0; checks_done = 0; cycles = 0;
    repeat (6) @(posedge clock_in);
    rst_b_in <= 1'b1;
    tick(5);
    s_reset(); s_pullup(); s_refuse(); s_drive(); s_led(); s_comp(); s_power_enable_input(); s_route();
    final_report();
  end
endmodule
`default_nettype wire
